// >>> src/csp_serial_ctrl.sv
// two-instance three-wire clocked serial port with its control registers
`timescale 1ns/100ps
`default_nettype none

module csp_serial_ctrl (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_bit_wr,
    input wire logic [2:0] cpu_bit_sel,
    input wire logic cpu_bit_val,
    input wire logic cpu_rd,
    output logic [7:0] cpu_rdata,
    input wire logic sclk0_in,
    input wire logic sclk1_in,
    input wire logic sdi0_pin,
    input wire logic sdi1_pin,
    input wire logic ssel1_n_pin,
    output logic sclk0_out,
    output logic sclk0_oe_n,
    output logic sclk1_out,
    output logic sclk1_oe_n,
    output logic sdo0_out,
    output logic sdo0_oe_n,
    output logic sdo1_out,
    output logic sdo1_oe_n
);
    logic [1:0][7:0] mode_q;
    logic [1:0][7:0] clk_q;
    logic [7:0] dir0_q;
    logic [7:0] dir1_q;
    logic [1:0] busy;
    logic [1:0][7:0] shr;
    logic [1:0] sck_o;
    logic [1:0] sdo_o;
    logic [1:0] link_clk;
    logic [1:0] sdi_pin;
    logic [1:0] sdi_s1;
    logic [1:0] sdi_s2;
    logic ssel_s1;
    logic ssel_s2;

    assign link_clk = {sclk1_in, sclk0_in};
    assign sdi_pin = {sdi1_pin, sdi0_pin};

    // byte write, or one bit replaced in the old value
    function automatic logic [7:0] merge(input logic [7:0] old);
        logic [7:0] v;
        v = old;
        if (cpu_bit_wr) begin
            v[cpu_bit_sel] = cpu_bit_val;
        end else begin
            v = cpu_wdata;
        end
        return v;
    endfunction : merge

    // **********************************
    // pin synchronisers
    // **********************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sdi_s1 <= 2'h0;
            sdi_s2 <= 2'h0;
            ssel_s1 <= 1'b1;
            ssel_s2 <= 1'b1;
        end else if (ce) begin
            sdi_s1 <= sdi_pin;
            sdi_s2 <= sdi_s1;
            ssel_s1 <= ssel1_n_pin;
            ssel_s2 <= ssel_s1;
        end
    end

    // **********************************
    // configuration registers
    // **********************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                mode_q[i] <= csp_pkg::MODE_RESET;
                clk_q[i] <= csp_pkg::CLK_RESET;
            end
        end else if (ce && (cpu_wr || cpu_bit_wr)) begin
            for (int i = 0; i < 2; i++) begin
                if (cpu_addr == csp_pkg::MODE_OFFSET[i]) begin
                    // busy and bits 3..1 are never stored
                    mode_q[i] <= merge(mode_q[i]) & csp_pkg::MODE_MASK[i];
                end
                if (cpu_addr == csp_pkg::CLK_OFFSET[i]) begin
                    clk_q[i] <= merge(clk_q[i]) & csp_pkg::CLK_MASK;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dir0_q <= csp_pkg::DIR_RESET;
            dir1_q <= csp_pkg::DIR_RESET;
        end else if (ce && (cpu_wr || cpu_bit_wr)) begin
            if (cpu_addr == csp_pkg::DIR0_OFFSET) begin
                dir0_q <= merge(dir0_q);
            end
            if (cpu_addr == csp_pkg::DIR1_OFFSET) begin
                dir1_q <= merge(dir1_q);
            end
        end
    end

    // **********************************
    // read port
    // **********************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cpu_rdata <= 8'h00;
        end else if (ce && cpu_rd) begin
            cpu_rdata <= 8'h00;
            if (cpu_addr == csp_pkg::DIR0_OFFSET) begin
                cpu_rdata <= dir0_q;
            end
            if (cpu_addr == csp_pkg::DIR1_OFFSET) begin
                cpu_rdata <= dir1_q;
            end
            for (int i = 0; i < 2; i++) begin
                if (cpu_addr == csp_pkg::MODE_OFFSET[i]) begin
                    cpu_rdata <= {mode_q[i][7:1], busy[i]};
                end
                if (cpu_addr == csp_pkg::CLK_OFFSET[i]) begin
                    cpu_rdata <= clk_q[i];
                end
                if (cpu_addr == csp_pkg::SHR_OFFSET[i]) begin
                    cpu_rdata <= shr[i];
                end
            end
        end
    end

    // **********************************
    // per-port engine
    // **********************************
    for (genvar i = 0; i < 2; i++) begin : g_ch
        logic en, trmd, sse, lsb, ckp, dap, slave, idle, crst;
        logic [2:0] code;
        logic [6:0] half_m1;
        logic [6:0] div;
        logic [3:0] edges;
        logic [2:0] cnt;
        logic sck_lvl, busy_q, out_q, so_q, sck_q;
        logic [7:0] sh;
        logic r_bit, r_tgl, f_bit, f_tgl;
        logic r1, r2, r3, f1, f2, f3;
        logic tick, rise_ev, fall_ev, lead, trail, samp, chg;
        logic din, done, ss_ok, start, ssel_lvl;
        assign en = mode_q[i][csp_pkg::EN_BIT];
        assign trmd = mode_q[i][csp_pkg::TRMD_BIT];
        assign sse = mode_q[i][csp_pkg::SSE_BIT];
        assign lsb = mode_q[i][csp_pkg::LSB_BIT];
        assign ckp = clk_q[i][csp_pkg::CKP_BIT];
        assign dap = clk_q[i][csp_pkg::DAP_BIT];
        assign code = clk_q[i][csp_pkg::CODE_MSB:0];
        assign slave = (code == csp_pkg::SLAVE_CODE);
        assign idle = ~ckp;
        // disable acts as an asynchronous reset of the engine
        assign crst = rst | ~en;
        assign half_m1 = (csp_pkg::DIV_ONE << code) - csp_pkg::DIV_ONE;
        assign ssel_lvl = (i == 1) ? ssel_s2 : 1'b0;
        // edges caught on the link clock itself
        always_ff @(posedge link_clk[i] or posedge crst) begin
            if (crst) begin
                r_bit <= 1'b0;
                r_tgl <= 1'b0;
            end else begin
                r_bit <= sdi_pin[i];
                r_tgl <= ~r_tgl;
            end
        end
        always_ff @(negedge link_clk[i] or posedge crst) begin
            if (crst) begin
                f_bit <= 1'b0;
                f_tgl <= 1'b0;
            end else begin
                f_bit <= sdi_pin[i];
                f_tgl <= ~f_tgl;
            end
        end
        // toggle crossing; the bit beside it is stable until the next edge
        always_ff @(posedge ref_clk or posedge crst) begin
            if (crst) begin
                r1 <= 1'b0;
                r2 <= 1'b0;
                r3 <= 1'b0;
                f1 <= 1'b0;
                f2 <= 1'b0;
                f3 <= 1'b0;
            end else if (ce) begin
                r1 <= r_tgl;
                r2 <= r1;
                r3 <= r2;
                f1 <= f_tgl;
                f2 <= f1;
                f3 <= f2;
            end
        end
        assign rise_ev = r2 ^ r3;
        assign fall_ev = f2 ^ f3;
        assign tick = busy_q & ~slave & (div == half_m1);
        assign lead = slave ? (idle ? fall_ev : rise_ev)
                            : (tick & (sck_lvl == idle));
        assign trail = slave ? (idle ? rise_ev : fall_ev)
                             : (tick & (sck_lvl != idle));
        assign samp = busy_q & (dap ? lead : trail);
        assign chg = busy_q & (dap ? trail : lead);
        assign din = slave ? ((dap ^ idle) ? r_bit : f_bit) : sdi_s2[i];
        assign done = slave ? (samp & (cnt == csp_pkg::LAST_SAMPLE))
                            : (tick & (edges == csp_pkg::LAST_EDGE));
        assign ss_ok = ~(slave & sse & ssel_lvl);
        assign start = en & ~busy_q & ss_ok & ce
            & ((trmd & cpu_wr & (cpu_addr == csp_pkg::TXB_OFFSET[i]))
            | (~trmd & cpu_rd & (cpu_addr == csp_pkg::SHR_OFFSET[i])));
        always_ff @(posedge ref_clk or posedge crst) begin
            if (crst) begin
                busy_q <= 1'b0;
            end else if (ce) begin
                if (start) begin
                    busy_q <= 1'b1;
                end else if (done) begin
                    busy_q <= 1'b0;
                end
            end
        end
        // master clock divider, sixteen half periods per byte
        always_ff @(posedge ref_clk or posedge crst) begin
            if (crst) begin
                div <= 7'h00;
                edges <= 4'h0;
                sck_lvl <= 1'b1;
            end else if (ce) begin
                if (!busy_q) begin
                    div <= 7'h00;
                    edges <= 4'h0;
                    sck_lvl <= idle;
                end else if (tick) begin
                    div <= 7'h00;
                    edges <= edges + 4'h1;
                    sck_lvl <= ~sck_lvl;
                end else if (!slave) begin
                    div <= div + 7'h01;
                end
            end
        end
        always_ff @(posedge ref_clk or posedge crst) begin
            if (crst) begin
                sh <= csp_pkg::SHR_RESET;
                cnt <= 3'h0;
            end else if (ce) begin
                if (start) begin
                    cnt <= 3'h0;
                    if (trmd) begin
                        sh <= cpu_wdata;
                    end
                end else if (samp) begin
                    cnt <= cnt + 3'h1;
                    sh <= lsb ? {din, sh[7:1]} : {sh[6:0], din};
                end
            end
        end
        always_ff @(posedge ref_clk or posedge crst) begin
            if (crst) begin
                out_q <= 1'b0;
            end else if (ce) begin
                if (start && dap) begin
                    out_q <= lsb ? cpu_wdata[0] : cpu_wdata[7];
                end else if (chg) begin
                    out_q <= lsb ? sh[0] : sh[7];
                end
            end
        end
        always_ff @(posedge ref_clk or posedge crst) begin
            if (crst) begin
                so_q <= 1'b0;
            end else if (ce) begin
                so_q <= trmd & out_q;
            end
        end
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                sck_q <= 1'b1;
            end else if (ce) begin
                sck_q <= (en & ~slave) ? sck_lvl : 1'b1;
            end
        end
        assign busy[i] = busy_q;
        assign shr[i] = sh;
        assign sck_o[i] = sck_q;
        assign sdo_o[i] = so_q;
    end
    // **********************************
    // pins
    // **********************************
    assign sclk0_out = sck_o[0];
    assign sclk1_out = sck_o[1];
    assign sdo0_out = sdo_o[0];
    assign sdo1_out = sdo_o[1];
    assign sclk0_oe_n = dir1_q[csp_pkg::SCK0_PIN];
    assign sdo0_oe_n = dir1_q[csp_pkg::SDO0_PIN];
    assign sclk1_oe_n = dir0_q[csp_pkg::SCK1_PIN];
    assign sdo1_oe_n = dir0_q[csp_pkg::SDO1_PIN];
endmodule : csp_serial_ctrl

`default_nettype wire

// >>> src/csp_pkg.sv
// constants for the clocked serial port control block
package csp_pkg;
    // **********************************
    // register offsets
    // **********************************
    localparam logic [15:0] DIR0_OFFSET = 16'hff20;
    localparam logic [15:0] DIR1_OFFSET = 16'hff21;
    localparam logic [1:0][15:0] MODE_OFFSET = {16'hff88, 16'hff80};
    localparam logic [1:0][15:0] CLK_OFFSET = {16'hff89, 16'hff81};
    localparam logic [1:0][15:0] TXB_OFFSET = {16'hff98, 16'hff90};
    localparam logic [1:0][15:0] SHR_OFFSET = {16'hff99, 16'hff91};

    // **********************************
    // reset values and writable masks
    // **********************************
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CLK_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] SHR_RESET = 8'h00;
    localparam logic [1:0][7:0] MODE_MASK = {8'hf0, 8'hd0};
    localparam logic [7:0] CLK_MASK = 8'h1f;

    // **********************************
    // field positions
    // **********************************
    localparam int EN_BIT = 7;
    localparam int TRMD_BIT = 6;
    localparam int SSE_BIT = 5;
    localparam int LSB_BIT = 4;
    localparam int BUSY_BIT = 0;
    localparam int CKP_BIT = 4;
    localparam int DAP_BIT = 3;
    localparam int CODE_MSB = 2;
    localparam int SCK0_PIN = 0;
    localparam int SDO0_PIN = 2;
    localparam int SCK1_PIN = 4;
    localparam int SDO1_PIN = 2;

    // **********************************
    // codes and counts
    // **********************************
    localparam logic [2:0] SLAVE_CODE = 3'h7;
    localparam logic [2:0] LAST_SAMPLE = 3'h7;
    localparam logic [3:0] LAST_EDGE = 4'hf;
    localparam logic [6:0] DIV_ONE = 7'h01;
endpackage : csp_pkg

// >>> bench/csp_assertions.sv
// concurrent checks on the serial port control block ports
`timescale 1ns/100ps
`default_nettype none
module csp_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_bit_wr,
    input wire logic [2:0] cpu_bit_sel,
    input wire logic cpu_bit_val,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_rdata,
    input wire logic sclk0_out,
    input wire logic sclk1_out,
    input wire logic sdo0_out,
    input wire logic sclk0_oe_n,
    input wire logic sdo0_oe_n,
    input wire logic sclk1_oe_n,
    input wire logic sdo1_oe_n
);
    // ****
    // register shadows
    // ****
    logic [1:0][7:0] m, c, d;
    logic [7:0] hc;

    function automatic logic [7:0] upd(logic [7:0] v, logic [15:0] a);
        upd = v;
        if (ce && cpu_wr && cpu_addr == a) upd = cpu_wdata;
        if (ce && cpu_bit_wr && cpu_addr == a) upd[cpu_bit_sel] = cpu_bit_val;
    endfunction : upd

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            m <= '0;
            c <= '0;
            d <= '1;
        end else begin
            m[0] <= upd(m[0], csp_pkg::MODE_OFFSET[0]);
            m[1] <= upd(m[1], csp_pkg::MODE_OFFSET[1]);
            c[0] <= upd(c[0], csp_pkg::CLK_OFFSET[0]);
            c[1] <= upd(c[1], csp_pkg::CLK_OFFSET[1]);
            d[0] <= upd(d[0], csp_pkg::DIR0_OFFSET);
            d[1] <= upd(d[1], csp_pkg::DIR1_OFFSET);
        end
    end

    // cycles since the last serial clock change
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hc <= 8'h00;
        end else if ($changed(sclk0_out)) begin
            hc <= 8'h01;
        end else if (hc != 8'hff) begin
            hc <= hc + 8'h01;
        end
    end

    // ****
    // properties
    // ****
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_reset_state: assert property (
        $past(rst) |-> cpu_rdata == 8'h00 && sclk0_oe_n && sdo0_oe_n
        && sclk1_oe_n && sdo1_oe_n) else $error("bad state after reset");
    a_dir_driver: assert property (
        $stable(d) |-> {sclk0_oe_n, sdo0_oe_n, sclk1_oe_n, sdo1_oe_n}
        == {d[1][0], d[1][2], d[0][4], d[0][2]}) else $error("bad enable");
    a_rx_only_quiet: assert property (
        !(m[0][7] && m[0][6]) [*2] |-> !sdo0_out) else $error("data not low");
    a_parked_clock: assert property (
        !m[0][7] [*2] |-> sclk0_out) else $error("clock moves while off");
    a_slave_clock: assert property (
        (c[1][2:0] == 3'h7) [*2] |-> sclk1_out) else $error("slave drove clock");
    a_master_rate: assert property (
        $rose(sclk0_out) && m[0][7] && c[0][2:0] != 3'h7
        |-> hc == (8'h01 << c[0][2:0])) else $error("bad clock rate");
    a_mode_readback: assert property (
        ce && cpu_rd && cpu_addr == csp_pkg::MODE_OFFSET[0]
        |=> cpu_rdata[7:1] == ($past(m[0][7:1]) & 7'h68)) else $error("bad mode");
    a_select_readback: assert property (
        ce && cpu_rd && cpu_addr == csp_pkg::MODE_OFFSET[1]
        |=> cpu_rdata[7:1] == ($past(m[1][7:1]) & 7'h78)) else $error("bad mode");
    a_cleared_shift: assert property (
        ce && cpu_rd && cpu_addr == csp_pkg::SHR_OFFSET[0] && !m[0][7]
        |=> cpu_rdata == 8'h00) else $error("shift not cleared");

    c_master_frame: cover property ($rose(sclk0_out) && m[0][7]);
    c_slave_set: cover property (m[1][7] && c[1][2:0] == 3'h7);
    c_abort: cover property ($fell(m[0][7]) && !sclk0_out);
endmodule : csp_checker
`default_nettype wire

// >>> bench/csp_peer.sv
// far-side peripheral model for the clocked serial port
`timescale 1ns/100ps
`default_nettype none
module csp_peer #(
    parameter bit SLAVE = 1'b0
) (
    input wire logic master_clk,
    input wire logic sdo,
    output logic link_clk,
    output logic sdi
);
    logic [7:0] shift = 8'h00;
    logic [7:0] rx = 8'h00;
    logic [7:0] edges = 8'h00;
    wire logic clk_used = SLAVE ? link_clk : master_clk;

    initial begin
        link_clk = 1'b1;
        sdi = 1'b0;
    end

    task automatic load(input logic [7:0] b);
        shift = b;
        edges = 8'h00;
    endtask : load

    // link clock only runs inside a frame
    task automatic frame();
        #1.3;
        repeat (8) begin
            link_clk = 1'b0;
            #16;
            link_clk = 1'b1;
            #16;
        end
    endtask : frame

    always @(negedge clk_used) begin
        sdi <= shift[7];
        shift <= {shift[6:0], 1'b0};
    end

    // line turns over once the byte is done
    always @(posedge clk_used) begin
        rx <= {rx[6:0], sdo};
        edges <= edges + 8'h01;
        if (edges == 8'h07) sdi <= ~sdi;
    end
endmodule : csp_peer
`default_nettype wire

// >>> bench/tb_top.sv
// testbench for the clocked serial port control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam logic [15:0] M0 = csp_pkg::MODE_OFFSET[0];
    localparam logic [15:0] M1 = csp_pkg::MODE_OFFSET[1];
    localparam logic [15:0] C0 = csp_pkg::CLK_OFFSET[0];
    localparam logic [15:0] C1 = csp_pkg::CLK_OFFSET[1];
    localparam logic [15:0] T0 = csp_pkg::TXB_OFFSET[0];
    localparam logic [15:0] T1 = csp_pkg::TXB_OFFSET[1];
    localparam logic [15:0] S0 = csp_pkg::SHR_OFFSET[0];
    localparam logic [15:0] S1 = csp_pkg::SHR_OFFSET[1];
    localparam logic [15:0] D0 = csp_pkg::DIR0_OFFSET;
    localparam logic [15:0] D1 = csp_pkg::DIR1_OFFSET;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [15:0] cpu_addr = 16'h0000;
    logic cpu_wr = 1'b0;
    logic [7:0] cpu_wdata = 8'h00;
    logic cpu_bit_wr = 1'b0;
    logic [2:0] cpu_bit_sel = 3'h0;
    logic cpu_bit_val = 1'b0;
    logic cpu_rd = 1'b0;
    logic ssel1_n_pin = 1'b1;
    logic [7:0] cpu_rdata, v;
    logic sclk0_in, sclk1_in, sdi0_pin, sdi1_pin, sclk0_out, sclk0_oe_n;
    logic sclk1_out, sclk1_oe_n, sdo0_out, sdo0_oe_n, sdo1_out, sdo1_oe_n;
    int mismatches = 0;
    int tests_run = 0;

    csp_serial_ctrl DUT (.ref_clk, .rst, .ce, .cpu_addr, .cpu_wr, .cpu_wdata,
        .cpu_bit_wr, .cpu_bit_sel, .cpu_bit_val, .cpu_rd, .cpu_rdata,
        .sclk0_in, .sclk1_in, .sdi0_pin, .sdi1_pin, .ssel1_n_pin, .sclk0_out,
        .sclk0_oe_n, .sclk1_out, .sclk1_oe_n, .sdo0_out, .sdo0_oe_n,
        .sdo1_out, .sdo1_oe_n);
    // released pins are pulled high
    csp_peer #(.SLAVE(1'b0)) p0 (.master_clk(sclk0_oe_n | sclk0_out),
        .sdo(sdo0_oe_n | sdo0_out), .link_clk(sclk0_in), .sdi(sdi0_pin));
    csp_peer #(.SLAVE(1'b1)) p1 (.master_clk(sclk1_oe_n | sclk1_out),
        .sdo(sdo1_oe_n | sdo1_out), .link_clk(sclk1_in), .sdi(sdi1_pin));

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(negedge ref_clk);
        cpu_wr = 1'b0;
    endtask : wr

    task automatic bw(input logic [15:0] a, input logic [2:0] s, input logic b);
        @(negedge ref_clk);
        cpu_addr = a;
        cpu_bit_sel = s;
        cpu_bit_val = b;
        cpu_bit_wr = 1'b1;
        @(negedge ref_clk);
        cpu_bit_wr = 1'b0;
    endtask : bw

    task automatic rd(input logic [15:0] a);
        @(negedge ref_clk);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge ref_clk);
        cpu_rd = 1'b0;
        v = cpu_rdata;
    endtask : rd

    task automatic rc(input logic [15:0] a, input logic [7:0] e);
        rd(a);
        chk(v, e);
    endtask : rc

    task automatic idle(input logic [15:0] a);
        int n = 0;
        rd(a);
        while (v[0] !== 1'b0 && n < 1000) begin
            rd(a);
            n++;
        end
        if (n == 1000) begin
            mismatches++;
            end_of_test();
        end
    endtask : idle

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        rc(M0, 8'h00);
        rc(C0, 8'h00);
        rc(D0, 8'hff);
        rc(D1, 8'hff);
        rc(M1, 8'h00);
        rc(C1, 8'h00);
        rc(16'hffff, 8'h00);
        chk({sclk0_oe_n, sdo0_oe_n, sclk1_oe_n, sdo1_oe_n}, 8'h0f);
        wr(C0, 8'hff);
        rc(C0, 8'h1f);
        wr(C0, 8'h00);
        wr(M0, 8'hff);
        rc(M0, 8'hd0);
        wr(M1, 8'hff);
        rc(M1, 8'hf0);
        wr(M0, 8'h00);
        wr(M1, 8'h00);
        bw(D1, 3'h0, 1'b0);
        bw(D1, 3'h2, 1'b0);
        bw(D0, 3'h2, 1'b0);
        rc(D1, 8'hfa);
        rc(D0, 8'hfb);
        chk({sclk0_oe_n, sdo0_oe_n, sdo1_oe_n}, 8'h00);
        $display("done: registers");
        for (int i = 0; i < 2; i++) begin
            wr(C0, i ? 8'h06 : 8'h02);
            wr(M0, i ? 8'h50 : 8'h40);
            bw(M0, 3'h7, 1'b1);
            p0.load(8'h4e);
            wr(T0, 8'ha1);
            rc(M0, i ? 8'hd1 : 8'hc1);
            idle(M0);
            chk(p0.rx, i ? 8'h85 : 8'ha1);
            chk(p0.edges, 8'h08);
            rc(S0, i ? 8'h72 : 8'h4e);
            wr(M0, 8'h00);
        end
        wr(C0, 8'h02);
        wr(M0, 8'h80);
        p0.load(8'hc3);
        rd(S0);
        idle(M0);
        chk(sdo0_out, 1'b0);
        rc(S0, 8'hc3);
        idle(M0);
        wr(M0, 8'h00);
        $display("done: exchange");
        wr(C0, 8'h06);
        wr(M0, 8'hc0);
        wr(T0, 8'hff);
        repeat (300) @(negedge ref_clk);
        wr(M0, 8'h00);
        rc(M0, 8'h00);
        rc(S0, 8'h00);
        for (int t = 0; t < 4; t++) begin
            wr(C0, 8'(t << 3));
            wr(M0, 8'h80);
            repeat (2) @(negedge ref_clk);
            chk(sclk0_out, !t[1]);
            wr(M0, 8'h00);
        end
        $display("done: abort and types");
        wr(C1, 8'h07);
        wr(M1, 8'he0);
        wr(T1, 8'h5a);
        rc(M1, 8'he0);
        ssel1_n_pin = 1'b0;
        repeat (4) @(negedge ref_clk);
        p1.load(8'h39);
        wr(T1, 8'h5a);
        p1.frame();
        idle(M1);
        rc(S1, 8'h39);
        chk(p1.rx, 8'h5a);
        ssel1_n_pin = 1'b1;
        wr(M1, 8'h00);
        $display("done: slave");
        end_of_test();
    end
endmodule : tb_top

bind csp_serial_ctrl csp_checker u_chk (.ref_clk, .rst, .ce, .cpu_addr,
    .cpu_wr, .cpu_wdata, .cpu_bit_wr, .cpu_bit_sel, .cpu_bit_val, .cpu_rd,
    .cpu_rdata, .sclk0_out, .sclk1_out, .sdo0_out, .sclk0_oe_n, .sdo0_oe_n,
    .sclk1_oe_n, .sdo1_oe_n);
`default_nettype wire
